// [rtl/cfg_pkg.sv]
// What this block does
// - start address fields drop their two low bits; sections sit on word boundaries.
// - message RAM lives from 0x8000; start fields hold the offset without that bit.
// - a receive or transmit element is an eight-byte header plus the payload size.
// - section and element size registers accept writes only with init and change-enable set.
// - in initialization mode the controller never drives the CAN bus.
// - standard filters serve standard identifiers; extended ones go to the extended list.
// - each enabled filter first matches by its type and two ids (a buffer filter by its first id alone), then runs its action.
// - an accepting filter reports its own index for the stored header.
// - accepted frames go to queue 0, queue 1 or buffers; priority may be flagged.
// - a filter word with bad check code flags an uncorrectable error, forces init.
// - a standard filter is one word: type 31:30, first id 26:16, 15:11 reserved.
// - no overlap checks; message RAM addresses wrap every 2 kB.
// - check codes update on writes; single-bit errors corrected, double-bit reported.
package cfg_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// address map
	localparam logic [15:0] MESSAGE_RAM_BASE      = 16'h8000;
	localparam int          MESSAGE_RAM_AW        = 9;
	localparam int          MESSAGE_RAM_WORDS     = 512;
	localparam int          MESSAGE_RAM_ADDR_LSB  = 2;
	localparam int          MESSAGE_RAM_ADDR_MSB  = 10;
	localparam int          NUM_SEC        = 7;
	localparam int          SEC_STD        = 0;
	localparam int          SEC_EXT        = 1;
	localparam logic [NUM_SEC-1:0][15:0] SEC_OFS = {
		16'h10F0, 16'h10C0, 16'h10B0, 16'h10AC, 16'h10A0, 16'h1088, 16'h1084};
	localparam logic [15:0] RX_ESC_OFS     = 16'h10BC;
	localparam logic [15:0] TX_ESC_OFS     = 16'h10C8;
	localparam logic [15:0] CORE_CTRL_OFS  = 16'h1010;
	localparam logic [15:0] STATUS_OFS     = 16'h1014;

	////////////////////////////////////////////////////////////////////////////////
	// fields and reset values
	localparam int          INIT_BIT       = 0;
	localparam int          CHG_EN_BIT     = 1;
	localparam int          ECC_ERR_BIT    = 0;
	localparam logic [31:0] CTRL_RESET     = 32'h0000_0001;
	localparam logic [31:0] SEC_RESET      = 32'h0000_0000;
	localparam logic [31:0] SEC_WMASK      = 32'hFFFF_FFFC;
	localparam int          CNT_LSB        = 16;
	localparam int          CNT_MSB        = 23;
	localparam logic [11:0] RX_ESC_WMASK   = 12'h777;
	localparam logic [2:0]  TX_ESC_WMASK   = 3'h7;
	localparam int          ESC_RX1_LSB    = 4;
	localparam int          ESC_RXB_LSB    = 8;

	////////////////////////////////////////////////////////////////////////////////
	// standard filter element
	localparam int          FT_MSB         = 31;
	localparam int          FT_LSB         = 30;
	localparam int          FA_MSB         = 29;
	localparam int          FA_LSB         = 27;
	localparam int          ID1_MSB        = 26;
	localparam int          ID1_LSB        = 16;
	localparam int          ID2_MSB        = 10;
	localparam int          BUFIDX_MSB     = 5;
	localparam logic [1:0]  FT_RANGE       = 2'h0;
	localparam logic [1:0]  FT_DUAL        = 2'h1;
	localparam logic [1:0]  FT_CLASSIC     = 2'h2;
	localparam logic [2:0]  FA_OFF         = 3'h0;
	localparam logic [2:0]  FA_Q0          = 3'h1;
	localparam logic [2:0]  FA_Q1          = 3'h2;
	localparam logic [2:0]  FA_REJECT      = 3'h3;
	localparam logic [2:0]  FA_PRIO        = 3'h4;
	localparam logic [2:0]  FA_PRIO_Q0     = 3'h5;
	localparam logic [2:0]  FA_PRIO_Q1     = 3'h6;
	localparam logic [2:0]  FA_BUFFER      = 3'h7;
	localparam logic [1:0]  DEST_Q0        = 2'h0;
	localparam logic [1:0]  DEST_Q1        = 2'h1;
	localparam logic [1:0]  DEST_BUF       = 2'h2;

	////////////////////////////////////////////////////////////////////////////////
	// element sizes
	localparam logic [7:0]  HDR_BYTES      = 8'h08;
	localparam logic [7:0][7:0] PAYLOAD_BYTES = {
		8'h40, 8'h30, 8'h20, 8'h18, 8'h14, 8'h10, 8'h0C, 8'h08};

	typedef enum logic [1:0] {ST_IDLE, ST_HOST_WAIT, ST_FILT_RD, ST_FILT_WAIT} walk_st_t;

	function automatic logic [7:0] elem_bytes(input logic [2:0] code);
		return HDR_BYTES + PAYLOAD_BYTES[code];
	endfunction

endpackage

// [rtl/message_ram_if.sv]
interface message_ram_if;
	logic                         re;
	logic                         we;
	logic [cfg_pkg::MESSAGE_RAM_AW-1:0]  addr;
	logic [31:0]                  wdata;
	logic [31:0]                  rdata;
	logic                         rvalid;
	logic                         corrected;
	logic                         uncorrectable;

	modport ctrl (output re, we, addr, wdata, input rdata, rvalid, corrected, uncorrectable);
	modport mem (input re, we, addr, wdata, output rdata, rvalid, corrected, uncorrectable);
endinterface

// [rtl/message_ram_store.sv]
module message_ram_store #(
	parameter int WORDS = cfg_pkg::MESSAGE_RAM_WORDS
) (
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst,
	// memory port
	message_ram_if.mem       port
);

	typedef struct packed {
		logic [38:0]      word;
		logic             rvalid;
		logic             rword_ok;
		logic [WORDS-1:0] written;
	} mstate_t;

	mstate_t     s_reg;
	mstate_t     s_next;
	logic [38:0] array [WORDS];
	logic [5:0]  syn;
	logic        par;
	logic [31:0] fixed;

	function automatic logic [5:0] check6(input logic [31:0] d);
		logic [5:0] acc;
		logic [5:0] n;
		acc = 6'h00;
		n = 6'h02;
		for (int j = 0; j < 32; j++) begin
			n = n + 6'h01;
			if ((n & (n - 6'h01)) == 6'h00) begin
				n = n + 6'h01;
			end
			if (d[j]) begin
				acc = acc ^ n;
			end
		end
		return acc;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// storage: check bits are formed only here, on the write path
	always_ff @(posedge i_clk) begin
		if (port.we) begin
			array[port.addr] <= {^{port.wdata, check6(port.wdata)}, check6(port.wdata), port.wdata};
		end
	end

	always_comb begin
		s_next = s_reg;
		s_next.rvalid = port.re;
		if (port.re) begin
			s_next.word = array[port.addr];
			s_next.rword_ok = s_reg.written[port.addr];
		end
		if (port.we) begin
			s_next.written[port.addr] = 1'b1;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// decode; a never-written word counts as uncorrectable since its code is garbage
	always_comb begin
		logic [5:0] n;
		n = 6'h02;
		syn = check6(s_reg.word[31:0]) ^ s_reg.word[37:32];
		par = ^s_reg.word;
		fixed = s_reg.word[31:0];
		for (int j = 0; j < 32; j++) begin
			n = n + 6'h01;
			if ((n & (n - 6'h01)) == 6'h00) begin
				n = n + 6'h01;
			end
			if (par && (syn == n)) begin
				fixed[j] = ~fixed[j];
			end
		end
	end

	assign port.rdata         = fixed;
	assign port.rvalid        = s_reg.rvalid;
	assign port.corrected     = s_reg.rvalid && s_reg.rword_ok && par;
	assign port.uncorrectable = s_reg.rvalid && (!s_reg.rword_ok || (!par && (syn != 6'h00)));

endmodule

// [rtl/msg_filter_cfg.sv]
module msg_filter_cfg (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// host register and memory access
	input  wire logic        i_req,
	input  wire logic        i_wr,
	input  wire logic [15:0] i_addr,
	input  wire logic [31:0] i_wdata,
	output logic             o_ready,
	output logic             o_ack,
	output logic [31:0]      o_rdata,
	// received identifier lookup
	input  wire logic        i_rx_valid,
	input  wire logic        i_rx_ext,
	input  wire logic [10:0] i_rx_id,
	output logic             o_rx_ready,
	output logic             o_rx_done,
	output logic             o_rx_accept,
	output logic             o_rx_matched,
	output logic             o_rx_ext_route,
	output logic [1:0]       o_rx_dest,
	output logic             o_rx_priority,
	output logic [7:0]       o_rx_filter_idx,
	output logic [5:0]       o_rx_buf_idx,
	// mode and layout
	output logic             o_init_mode,
	output logic             o_can_drive_en,
	output logic             o_beu,
	output logic [7:0]       o_rx0_elem_bytes,
	output logic [7:0]       o_rx1_elem_bytes,
	output logic [7:0]       o_rxbuf_elem_bytes,
	output logic [7:0]       o_tx_elem_bytes
);

	typedef struct packed {
		cfg_pkg::walk_st_t                st;
		logic [31:0]                      ctrl;
		logic                             uncorrectable_bit_error;
		logic [cfg_pkg::NUM_SEC-1:0][31:0] sec;
		logic [11:0]                      rx_esc;
		logic [2:0]                       tx_esc;
		logic [7:0]                       idx;
		logic [10:0]                      id;
		logic                             ack;
		logic [31:0]                      rdata;
		logic                             done;
		logic                             accept;
		logic                             matched;
		logic                             ext;
		logic [1:0]                       dest;
		logic                             prio;
		logic [7:0]                       fidx;
		logic [5:0]                       bufidx;
	} state_t;

	state_t      s_reg;
	state_t      s_next;
	message_ram_if      mem ();
	logic        unlocked;
	logic        is_message_ram;
	logic        take_host;
	logic        take_rx;
	logic [7:0]  std_count;
	logic [31:0] w;
	logic        hit;
	logic [2:0]  fa;

	message_ram_store #(
		.WORDS (cfg_pkg::MESSAGE_RAM_WORDS)
	) u_store (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.port  (mem.mem)
	);

	assign unlocked  = s_reg.ctrl[cfg_pkg::INIT_BIT] && s_reg.ctrl[cfg_pkg::CHG_EN_BIT];
	assign is_message_ram   = i_addr[15] == cfg_pkg::MESSAGE_RAM_BASE[15];
	assign o_ready   = s_reg.st == cfg_pkg::ST_IDLE;
	assign take_host = o_ready && i_req;
	assign o_rx_ready = o_ready && !i_req && !s_reg.ctrl[cfg_pkg::INIT_BIT];
	assign take_rx   = o_rx_ready && i_rx_valid;
	assign std_count = s_reg.sec[cfg_pkg::SEC_STD][cfg_pkg::CNT_MSB:cfg_pkg::CNT_LSB];
	assign w         = mem.rdata;
	assign fa        = w[cfg_pkg::FA_MSB:cfg_pkg::FA_LSB];

	////////////////////////////////////////////////////////////////////////////////
	// memory port: the high address bits are dropped, so 0x8800 lands on word 0
	assign mem.we    = take_host && i_wr && is_message_ram;
	assign mem.re    = (take_host && !i_wr && is_message_ram) || (s_reg.st == cfg_pkg::ST_FILT_RD);
	assign mem.wdata = i_wdata;
	assign mem.addr  = (s_reg.st == cfg_pkg::ST_FILT_RD) ?
		s_reg.sec[cfg_pkg::SEC_STD][cfg_pkg::MESSAGE_RAM_ADDR_MSB:cfg_pkg::MESSAGE_RAM_ADDR_LSB] + {1'b0, s_reg.idx} :
		i_addr[cfg_pkg::MESSAGE_RAM_ADDR_MSB:cfg_pkg::MESSAGE_RAM_ADDR_LSB];

	////////////////////////////////////////////////////////////////////////////////
	// filter element match
	always_comb begin
		hit = 1'b0;
		if (fa == cfg_pkg::FA_BUFFER) begin
			hit = s_reg.id == w[cfg_pkg::ID1_MSB:cfg_pkg::ID1_LSB];
		end else if (fa != cfg_pkg::FA_OFF) begin
			unique case (w[cfg_pkg::FT_MSB:cfg_pkg::FT_LSB])
				cfg_pkg::FT_RANGE: begin
					hit = (s_reg.id >= w[cfg_pkg::ID1_MSB:cfg_pkg::ID1_LSB]) &&
						(s_reg.id <= w[cfg_pkg::ID2_MSB:0]);
				end
				cfg_pkg::FT_DUAL: begin
					hit = (s_reg.id == w[cfg_pkg::ID1_MSB:cfg_pkg::ID1_LSB]) || (s_reg.id == w[cfg_pkg::ID2_MSB:0]);
				end
				cfg_pkg::FT_CLASSIC: begin
					hit = ((s_reg.id ^ w[cfg_pkg::ID1_MSB:cfg_pkg::ID1_LSB]) & w[cfg_pkg::ID2_MSB:0]) == 11'h000;
				end
				default: begin
					hit = 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		s_next = s_reg;
		s_next.ack = 1'b0;
		s_next.done = 1'b0;
		unique case (s_reg.st)
			cfg_pkg::ST_IDLE: begin
				if (take_host && is_message_ram) begin
					s_next.ack = i_wr;
					s_next.st = i_wr ? cfg_pkg::ST_IDLE : cfg_pkg::ST_HOST_WAIT;
				end else if (take_host) begin
					s_next.ack = 1'b1;
					s_next.rdata = 32'h0000_0000;
					for (int k = 0; k < cfg_pkg::NUM_SEC; k++) begin
						if (i_addr == cfg_pkg::SEC_OFS[k]) begin
							s_next.rdata = s_reg.sec[k];
							if (i_wr && unlocked) begin
								s_next.sec[k] = i_wdata & cfg_pkg::SEC_WMASK;
							end
						end
					end
					if (i_addr == cfg_pkg::RX_ESC_OFS) begin
						s_next.rdata = {20'h00000, s_reg.rx_esc};
						if (i_wr && unlocked) begin
							s_next.rx_esc = i_wdata[11:0] & cfg_pkg::RX_ESC_WMASK;
						end
					end
					if (i_addr == cfg_pkg::TX_ESC_OFS) begin
						s_next.rdata = {29'h00000000, s_reg.tx_esc};
						if (i_wr && unlocked) begin
							s_next.tx_esc = i_wdata[2:0] & cfg_pkg::TX_ESC_WMASK;
						end
					end
					if (i_addr == cfg_pkg::CORE_CTRL_OFS) begin
						s_next.rdata = s_reg.ctrl;
						if (i_wr) begin
							// change-enable only sticks while init is being kept set
							s_next.ctrl = 32'h0000_0000;
							s_next.ctrl[cfg_pkg::INIT_BIT] = i_wdata[cfg_pkg::INIT_BIT];
							s_next.ctrl[cfg_pkg::CHG_EN_BIT] = i_wdata[cfg_pkg::INIT_BIT] && i_wdata[cfg_pkg::CHG_EN_BIT];
						end
					end
					if (i_addr == cfg_pkg::STATUS_OFS) begin
						s_next.rdata = {31'h00000000, s_reg.uncorrectable_bit_error};
						if (i_wr && i_wdata[cfg_pkg::ECC_ERR_BIT]) begin
							s_next.uncorrectable_bit_error = 1'b0;
						end
					end
				end else if (take_rx) begin
					s_next.id = i_rx_id;
					s_next.idx = 8'h00;
					s_next.prio = 1'b0;
					s_next.matched = 1'b0;
					s_next.ext = i_rx_ext;
					s_next.dest = cfg_pkg::DEST_Q0;
					s_next.accept = !i_rx_ext;
					if (i_rx_ext || (std_count == 8'h00)) begin
						s_next.done = 1'b1;
					end else begin
						s_next.st = cfg_pkg::ST_FILT_RD;
					end
				end
			end
			cfg_pkg::ST_HOST_WAIT: begin
				if (mem.rvalid) begin
					s_next.ack = 1'b1;
					s_next.rdata = mem.rdata;
					s_next.st = cfg_pkg::ST_IDLE;
				end
			end
			cfg_pkg::ST_FILT_RD: begin
				s_next.st = cfg_pkg::ST_FILT_WAIT;
			end
			cfg_pkg::ST_FILT_WAIT: begin
				if (mem.rvalid) begin
					s_next.st = cfg_pkg::ST_IDLE;
					s_next.done = 1'b1;
					if (mem.uncorrectable) begin
						s_next.accept = 1'b0;
						s_next.ctrl[cfg_pkg::INIT_BIT] = 1'b1;
					end else if (hit && (fa != cfg_pkg::FA_PRIO)) begin
						s_next.matched = 1'b1;
						s_next.fidx = s_reg.idx;
						s_next.accept = fa != cfg_pkg::FA_REJECT;
						s_next.prio = s_reg.prio || (fa == cfg_pkg::FA_PRIO_Q0) || (fa == cfg_pkg::FA_PRIO_Q1);
						s_next.dest = ((fa == cfg_pkg::FA_Q1) || (fa == cfg_pkg::FA_PRIO_Q1)) ? cfg_pkg::DEST_Q1 :
							(fa == cfg_pkg::FA_BUFFER) ? cfg_pkg::DEST_BUF : cfg_pkg::DEST_Q0;
						s_next.bufidx = w[cfg_pkg::BUFIDX_MSB:0];
					end else begin
						// priority-only hits keep walking; storage comes from a later filter or the default
						s_next.prio = s_reg.prio || hit;
						if ((s_reg.idx + 8'h01) != std_count) begin
							s_next.idx = s_reg.idx + 8'h01;
							s_next.st = cfg_pkg::ST_FILT_RD;
							s_next.done = 1'b0;
						end
					end
				end
			end
		endcase
		if (mem.uncorrectable) begin
			s_next.uncorrectable_bit_error = 1'b1;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s_reg <= '0;
			s_reg.ctrl <= cfg_pkg::CTRL_RESET;
			s_reg.sec <= {cfg_pkg::NUM_SEC{cfg_pkg::SEC_RESET}};
		end else begin
			s_reg <= s_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs
	assign o_ack              = s_reg.ack;
	assign o_rdata            = s_reg.rdata;
	assign o_rx_done          = s_reg.done;
	assign o_rx_accept        = s_reg.accept;
	assign o_rx_matched       = s_reg.matched;
	assign o_rx_ext_route     = s_reg.ext;
	assign o_rx_dest          = s_reg.dest;
	assign o_rx_priority      = s_reg.prio;
	assign o_rx_filter_idx    = s_reg.fidx;
	assign o_rx_buf_idx       = s_reg.bufidx;
	assign o_init_mode        = s_reg.ctrl[cfg_pkg::INIT_BIT];
	assign o_can_drive_en     = !s_reg.ctrl[cfg_pkg::INIT_BIT];
	assign o_beu              = s_reg.uncorrectable_bit_error;
	assign o_rx0_elem_bytes   = cfg_pkg::elem_bytes(s_reg.rx_esc[2:0]);
	assign o_rx1_elem_bytes   = cfg_pkg::elem_bytes(s_reg.rx_esc[cfg_pkg::ESC_RX1_LSB +: 3]);
	assign o_rxbuf_elem_bytes = cfg_pkg::elem_bytes(s_reg.rx_esc[cfg_pkg::ESC_RXB_LSB +: 3]);
	assign o_tx_elem_bytes    = cfg_pkg::elem_bytes(s_reg.tx_esc);

	////////////////////////////////////////////////////////////////////////////////
	// checks
	localparam int WALK_MAX = 520;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	sequence std_lookup_s;
		take_rx && !i_rx_ext && (std_count != 8'h00);
	endsequence

	sequence walk_end_s;
		o_rx_done && !o_rx_ext_route;
	endsequence

	cfg_locked_a: assert property (take_host && i_wr && !unlocked && (i_addr == cfg_pkg::SEC_OFS[2])
		|=> $stable(s_reg.sec[2])) else $error("section config changed while locked");
	bus_quiet_a: assert property (o_init_mode |-> !o_can_drive_en)
		else $error("bus driven in init mode");
	start_align_a: assert property (s_reg.sec[cfg_pkg::SEC_STD][1:0] == 2'h0)
		else $error("start address low bits kept");
	ext_bypass_a: assert property (take_rx && i_rx_ext |-> !mem.re ##1 (o_rx_done && o_rx_ext_route && !o_rx_accept))
		else $error("extended id not routed away");
	walk_bound_a: assert property (std_lookup_s |-> ##[1:WALK_MAX] walk_end_s)
		else $error("filter walk did not finish");
	beu_init_a: assert property (s_reg.st == cfg_pkg::ST_FILT_WAIT && mem.uncorrectable
		|=> o_beu && o_init_mode && o_rx_done && !o_rx_accept) else $error("bad filter word not trapped");
	message_ram_wrap_a: assert property (take_host && is_message_ram |-> mem.addr == i_addr[10:2])
		else $error("message ram address not wrapped");
	elem_size_a: assert property (s_reg.rx_esc[2:0] == 3'h6 |-> o_rx0_elem_bytes == 8'h38)
		else $error("48-byte payload element size wrong");
	filter_index_a: assert property (o_rx_done && o_rx_matched |-> o_rx_filter_idx < std_count)
		else $error("filter index outside list");

endmodule

// [testbench/host_model.sv]
module host_model (
	// clock and bus answer
	input  wire logic        i_clk,
	input  wire logic        i_ready,
	input  wire logic        i_ack,
	input  wire logic [31:0] i_rdata,
	// bus request
	output logic             o_req,
	output logic             o_wr,
	output logic [15:0]      o_addr,
	output logic [31:0]      o_wdata
);
	timeunit 1ns;
	timeprecision 1ns;

	// counts bus waits that ran out; the bench adds it to its mismatches
	int tmo = 0;

	initial begin
		o_req = 1'b0;
		o_wr = 1'b0;
		o_addr = 16'h0000;
		o_wdata = 32'h0000_0000;
	end

	////////////////////////////////////////////////////////////////////////////////
	// one word access: waits for ready, pulses the request, then waits for the answer
	task automatic acc(input logic wr, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		while (i_ready !== 1'b1 && n < 16) begin
			@(posedge i_clk);
			n++;
		end
		if (n == 16)
			tmo++;
		@(posedge i_clk);
		o_req <= 1'b1;
		o_wr <= wr;
		o_addr <= a;
		o_wdata <= d;
		@(posedge i_clk);
		o_req <= 1'b0;
		// released data is inverted so a stale value cannot pass for a fresh one
		o_wdata <= ~d;
		o_addr <= ~a;
		#1;
		n = 0;
		while (i_ack !== 1'b1 && n < 8) begin
			@(posedge i_clk);
			#1;
			n++;
		end
		if (n == 8)
			tmo++;
		q = i_rdata;
	endtask

	// memory words are always reached with the base prefix set
	task automatic message_ram(input logic wr, input logic [15:0] ofs, input logic [31:0] d, output logic [31:0] q);
		acc(wr, cfg_pkg::MESSAGE_RAM_BASE | ofs, d, q);
	endtask
endmodule

// [testbench/message_ram_filter_config_tb.sv]
module message_ram_filter_config_tb;
	timeunit 1ns;
	timeprecision 1ns;

	localparam logic [31:0] SEC_VAL [7] = '{32'h0002_0000, 32'h0001_0008, 32'h0204_0010, 32'h0000_0000,
		32'h0305_00F0, 32'h0A00_0270, 32'h0203_0258};
	localparam int          PAY [8] = '{8, 12, 16, 20, 24, 32, 48, 64};
	localparam logic [31:0] FILT [4] = '{{cfg_pkg::FT_CLASSIC, cfg_pkg::FA_Q1, 11'h12F, 5'h00, 11'h0FF},
		{cfg_pkg::FT_DUAL, cfg_pkg::FA_BUFFER, 11'h055, 5'h00, 11'h005},
		{cfg_pkg::FT_RANGE, cfg_pkg::FA_PRIO, 11'h100, 5'h00, 11'h1FF},
		{cfg_pkg::FT_DUAL, cfg_pkg::FA_REJECT, 11'h3AF, 5'h00, 11'h7FF}};

	logic        i_clk = 1'b0;
	logic        i_rst = 1'b1;
	logic        rx_valid = 1'b0;
	logic        rx_ext = 1'b0;
	logic [10:0] rx_id = 11'h000;
	logic        req, wr, o_ready, o_ack, o_rx_ready, o_rx_done, o_rx_accept, o_rx_matched, o_rx_ext_route;
	logic        o_rx_priority, o_init_mode, o_can_drive_en, o_beu;
	logic [15:0] addr;
	logic [31:0] wdata, o_rdata;
	logic [1:0]  o_rx_dest;
	logic [7:0]  o_rx_filter_idx, o_rx0_elem_bytes, o_rx1_elem_bytes, o_rxbuf_elem_bytes, o_tx_elem_bytes;
	logic [5:0]  o_rx_buf_idx;
	logic [19:0] rxv;
	int          err_count = 0;
	int          cmp_count = 0;

	assign rxv = {o_rx_accept, o_rx_matched, o_rx_ext_route, o_rx_dest, o_rx_priority, o_rx_filter_idx, o_rx_buf_idx};

	always #4 i_clk = ~i_clk;

	msg_filter_cfg uut (.i_clk(i_clk), .i_rst(i_rst), .i_req(req), .i_wr(wr), .i_addr(addr), .i_wdata(wdata),
		.o_ready(o_ready), .o_ack(o_ack), .o_rdata(o_rdata), .i_rx_valid(rx_valid), .i_rx_ext(rx_ext),
		.i_rx_id(rx_id), .o_rx_ready(o_rx_ready), .o_rx_done(o_rx_done), .o_rx_accept(o_rx_accept),
		.o_rx_matched(o_rx_matched), .o_rx_ext_route(o_rx_ext_route), .o_rx_dest(o_rx_dest),
		.o_rx_priority(o_rx_priority), .o_rx_filter_idx(o_rx_filter_idx), .o_rx_buf_idx(o_rx_buf_idx),
		.o_init_mode(o_init_mode), .o_can_drive_en(o_can_drive_en), .o_beu(o_beu),
		.o_rx0_elem_bytes(o_rx0_elem_bytes), .o_rx1_elem_bytes(o_rx1_elem_bytes),
		.o_rxbuf_elem_bytes(o_rxbuf_elem_bytes), .o_tx_elem_bytes(o_tx_elem_bytes));

	host_model host (.i_clk(i_clk), .i_ready(o_ready), .i_ack(o_ack), .i_rdata(o_rdata), .o_req(req), .o_wr(wr),
		.o_addr(addr), .o_wdata(wdata));

	////////////////////////////////////////////////////////////////////////////////
	// checking
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string msg);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic chk_rx(input logic [19:0] got, input logic [19:0] exp, input logic [19:0] care, input string msg);
		cmp_count++;
		if ((got & care) !== (exp & care)) begin
			err_count++;
			$display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic finish_test();
		err_count += host.tmo;
		$display("compares %0d errors %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// reference walk over the first cnt filter words; index only matters on a match
	function automatic void model(input int id, input int cnt, output logic [19:0] e, output logic [19:0] care);
		int  t, a, i1, i2;
		logic hit, pr;
		pr = 1'b0;
		e = {1'b1, 1'b0, 1'b0, cfg_pkg::DEST_Q0, 1'b0, 14'h0000};
		care = 20'hD_C000;
		for (int k = 0; k < cnt; k++) begin
			t = FILT[k][31:30];
			a = FILT[k][29:27];
			i1 = FILT[k][26:16];
			i2 = FILT[k][10:0];
			if (a == 7)
				hit = (id == i1);
			else if (a == 0 || t == 3)
				hit = 1'b0;
			else if (t == 0)
				hit = (id >= i1 && id <= i2);
			else if (t == 1)
				hit = (id == i1 || id == i2);
			else
				hit = (((id ^ i1) & i2) == 0);
			if (hit && a == 4)
				pr = 1'b1;
			else if (hit) begin
				e = {a != 3, 1'b1, 1'b0, (a == 7) ? cfg_pkg::DEST_BUF : (a == 2 || a == 6) ? cfg_pkg::DEST_Q1 :
					cfg_pkg::DEST_Q0, pr || a == 5 || a == 6, 8'(k), FILT[k][5:0]};
				care = {2'b11, 1'b0, (a == 3) ? 2'b00 : 2'b11, 1'b1, 8'hFF, (a == 7) ? 6'h3F : 6'h00};
				return;
			end
		end
		e[14] = pr;
	endfunction

	task automatic look(input logic ext, input logic [10:0] id);
		int n;
		@(posedge i_clk);
		rx_valid <= 1'b1;
		rx_ext <= ext;
		rx_id <= id;
		@(posedge i_clk);
		rx_valid <= 1'b0;
		rx_id <= ~id;
		#1;
		n = 0;
		while (o_rx_done !== 1'b1 && n < 40) begin
			@(posedge i_clk);
			#1;
			n++;
		end
		if (n == 40) begin
			err_count++;
			$display("[ERR] %0t lookup did not finish", $time);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// tests
	initial begin
		#100000;
		err_count++;
		finish_test();
	end

	initial begin
		logic [31:0] q;
		logic [19:0] e, care;
		int          ids [$];
		void'($urandom(89));
		repeat (8) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		chk_reg(32'({o_init_mode, o_can_drive_en}), 32'h2, "init mode after reset");
		host.acc(1'b1, cfg_pkg::SEC_OFS[0], SEC_VAL[0], q);
		host.acc(1'b0, cfg_pkg::SEC_OFS[0], 32'h0000_0000, q);
		chk_reg(q, 32'h0000_0000, "write without change enable");
		host.acc(1'b1, cfg_pkg::CORE_CTRL_OFS, 32'h0000_0003, q);
		for (int i = 0; i < 7; i++) begin
			host.acc(1'b1, cfg_pkg::SEC_OFS[i], SEC_VAL[i] | 32'h0000_0003, q);
			host.acc(1'b0, cfg_pkg::SEC_OFS[i], 32'h0000_0000, q);
			chk_reg(q, SEC_VAL[i], "section register");
		end
		host.acc(1'b1, cfg_pkg::RX_ESC_OFS, 32'h0000_0076, q);
		host.acc(1'b1, cfg_pkg::TX_ESC_OFS, 32'h0000_0007, q);
		chk_reg({o_rx0_elem_bytes, o_rx1_elem_bytes, o_rxbuf_elem_bytes, o_tx_elem_bytes},
			{8'(8 + PAY[6]), 8'(8 + PAY[7]), 8'(8 + PAY[0]), 8'(8 + PAY[7])}, "element sizes");
		host.acc(1'b0, 16'h1200, 32'h0000_0000, q);
		chk_reg(q, 32'h0000_0000, "unmapped read");
		foreach (FILT[k]) host.message_ram(1'b1, 16'(4 * k), FILT[k], q);
		host.message_ram(1'b0, 16'h0800, 32'h0000_0000, q);
		chk_reg(q, FILT[0], "wrapped address");
		host.message_ram(1'b0, 16'h0004, 32'h0000_0000, q);
		chk_reg(q, FILT[1], "filter word");
		host.acc(1'b1, cfg_pkg::CORE_CTRL_OFS, 32'h0000_0000, q);
		host.acc(1'b1, cfg_pkg::SEC_OFS[0], 32'h0009_0000, q);
		host.acc(1'b0, cfg_pkg::SEC_OFS[0], 32'h0000_0000, q);
		chk_reg(q, SEC_VAL[0], "locked outside init");
		chk_reg(32'({o_init_mode, o_can_drive_en}), 32'h1, "running mode");
		ids = '{11'h12F, 11'h3AF, 11'h055, 11'h12E, 11'h150, 11'h1AF};
		repeat (16) ids.push_back($urandom_range(0, 2047));
		// second pass widens the list to reach range, priority-only and reject filters
		for (int p = 2; p <= 4; p += 2) begin
			if (p == 4) begin
				host.acc(1'b1, cfg_pkg::CORE_CTRL_OFS, 32'h0000_0003, q);
				host.acc(1'b1, cfg_pkg::SEC_OFS[0], 32'h0004_0000, q);
				host.acc(1'b1, cfg_pkg::CORE_CTRL_OFS, 32'h0000_0000, q);
			end
			foreach (ids[n]) begin
				look(1'b0, 11'(ids[n]));
				model(ids[n], p, e, care);
				chk_rx(rxv, e, care, "standard lookup");
			end
		end
		look(1'b1, 11'h12F);
		chk_rx(rxv, 20'h2_0000, 20'hA_0000, "extended lookup");
		host.acc(1'b1, cfg_pkg::CORE_CTRL_OFS, 32'h0000_0003, q);
		host.acc(1'b1, cfg_pkg::SEC_OFS[0], 32'h0005_0000, q);
		host.acc(1'b1, cfg_pkg::CORE_CTRL_OFS, 32'h0000_0000, q);
		look(1'b0, 11'h000);
		chk_reg(32'({o_rx_accept, o_beu, o_init_mode}), 32'h3, "unwritten filter word");
		host.acc(1'b0, cfg_pkg::STATUS_OFS, 32'h0000_0000, q);
		chk_reg(q & 32'h0000_0001, 32'h0000_0001, "error status");
		finish_test();
	end
endmodule
